/* design/ddil_top.v */
// drive digital input conditioning: terminal sampling, polarity,
// fixed jog/run mapping, programmable routing and enable cutoff.
// assumes one clock, synchronous reset, registers on a plain port, and
// ramp hold and running levels from logic on the same clock.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "ddil_map.vh"

// Operation
// - each input terminal state is readable: 0 inactive, 1 active
// - start allowed only while run permit active; status 0 stop, 1 start
// - run permit inactive forces the pre-ramp speed reference to zero
// - losing run permit stops the drive unless ramp hold is active
// - inputs two and three are jog reverse/forward when mapping bit is 0
// - inputs four and five are run reverse/forward when mapping bit is 0
// - with mapping bit 0, run inputs latch the reference-on flag
// - drive operates only while enable input active; status 0/1
// - enable removal switches firing pulses off after 30 ms
// - enable removal while running gives coast stop and ramp reset
// - inputs two to ten each have a destination 0..1999, default 0
// - a changed destination takes effect only after a reset action
// - mapping bit 1 drops fixed mapping; default of the bit is 0 (here jog/run stay on inputs two to five, allow-gated)
// - programmable input drives reference-on only with run permit
// - per input polarity bit: 0 passes, 1 inverts the function
// - with mapping bit 1, four allow bits gate jog and run functions
module ddil_top #(
  parameter OFF_DELAY_CYCLES = `DDIL_OFF_DELAY_MS * `DDIL_CLK_KHZ,
  parameter OFF_DELAY_CW     = 22
) (
  input  wire                              core_clk,
  input  wire                              rst_n,
  // register port
  input  wire [`DDIL_AW-1:0]               reg_addr,
  input  wire [`DDIL_DW-1:0]               reg_wdata,
  input  wire                              reg_wr,
  input  wire                              reg_rd,
  output reg  [`DDIL_DW-1:0]               reg_rdata,
  // terminals
  input  wire                              run_permit_input,
  input  wire                              logic_input_two,
  input  wire                              logic_input_three,
  input  wire                              logic_input_four,
  input  wire                              logic_input_five,
  input  wire                              logic_input_six,
  input  wire                              logic_input_seven,
  input  wire                              logic_input_eight,
  input  wire                              logic_input_nine,
  input  wire                              logic_input_ten,
  input  wire                              drive_enable_input,
  input  wire                              reset_button,
  // levels from the ramp and bridge logic
  input  wire                              ramp_hold,
  input  wire                              drive_running,
  // commands to the drive
  output reg                               start_allowed,
  output reg                               speed_ref_zero,
  output reg                               stop_request,
  output reg                               jog_rev_cmd,
  output reg                               jog_fwd_cmd,
  output reg                               run_rev_cmd,
  output reg                               run_fwd_cmd,
  output reg                               reference_on,
  output reg                               drive_operate,
  output wire                              firing_on,
  output reg                               coast_stop,
  output reg                               ramp_reset,
  // programmable routing towards the parameter space
  output wire [`DDIL_NIN*`DDIL_DEST_W-1:0] route_dest,
  output wire [`DDIL_NIN-1:0]              route_level
);

  localparam NIN = `DDIL_NIN;
  localparam DW  = `DDIL_DW;
  localparam SW  = NIN + 3;

  // synchronised terminals
  wire [SW-1:0]  term_raw;
  wire [SW-1:0]  term_sync;
  wire           permit_s;
  wire [NIN-1:0] in_s;
  wire           enable_s;
  wire           reset_btn_s;

  // software settings
  reg            fixed_off;
  reg  [NIN-1:0] polarity;
  reg  [3:0]     allow;

  // derived terms
  wire [NIN-1:0] cond;
  wire [NIN-1:0] ref_hit;
  wire [NIN*DW-1:0] rd_vec;
  reg            reset_btn_d;
  reg            enable_d;
  wire           apply_evt;
  wire           wr_apply;
  reg  [DW-1:0]  next_rdata;
  reg  [DW-1:0]  rd_target;
  reg            next_ref_on;
  integer        k;

  // terminal order in the synchroniser word, permit in bit 0
  assign term_raw = {reset_button, drive_enable_input,
                     logic_input_ten, logic_input_nine,
                     logic_input_eight, logic_input_seven,
                     logic_input_six, logic_input_five,
                     logic_input_four, logic_input_three,
                     logic_input_two, run_permit_input};

  // every terminal crosses in through two flops before use
  ddil_sync #(
    .W    (SW)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (term_raw),
    .dout     (term_sync)
  );

  assign permit_s    = term_sync[0];
  assign in_s        = term_sync[NIN:1];
  assign enable_s    = term_sync[NIN+1];
  assign reset_btn_s = term_sync[NIN+2];

  // enable loss cutoff timer
  ddil_delay #(
    .CYCLES (OFF_DELAY_CYCLES),
    .CW     (OFF_DELAY_CW)
  ) u_delay (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .enable_ok (enable_s),
    .firing_on (firing_on)
  );

  // reset action: the pushbutton edge or a software apply write
  assign wr_apply  = reg_wr && (reg_addr == `DDIL_A_APPLY);
  assign apply_evt = wr_apply || (reset_btn_s && !reset_btn_d);

  // per input entry: polarity, pending and applied destination
  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : g_in
      localparam integer AI = g + `DDIL_A_TARGET0;
      reg [`DDIL_DEST_W-1:0] target;
      reg [`DDIL_DEST_W-1:0] applied;
      reg                    level;

      assign cond[g] = in_s[g] ^ polarity[g];

      // out-of-range writes are dropped, the old setting stays
      always @(posedge core_clk) begin
        if (!rst_n) begin
          target  <= `DDIL_DEST_RST;
          applied <= `DDIL_DEST_RST;
          level   <= 1'b0;
        end else begin
          if (reg_wr && (reg_addr == AI[`DDIL_AW-1:0]) &&
              (reg_wdata[DW-1:`DDIL_DEST_W] == 5'h00) &&
              (reg_wdata[`DDIL_DEST_W-1:0] <= `DDIL_DEST_MAX)) begin
            target <= reg_wdata[`DDIL_DEST_W-1:0];
          end
          if (apply_evt) begin
            applied <= target;
          end
          level <= cond[g];
        end
      end

      assign ref_hit[g] = cond[g] && (applied == `DDIL_REF_ON_DEST);
      assign rd_vec[g*DW +: DW] =
        (reg_addr == AI[`DDIL_AW-1:0]) ? {5'h00, target} : 16'h0000;
      assign route_dest[g*`DDIL_DEST_W +: `DDIL_DEST_W] = applied;
      assign route_level[g] = level;
    end
  endgenerate

  // software settings and edge history
  always @(posedge core_clk) begin
    if (!rst_n) begin
      fixed_off   <= 1'b0;
      polarity    <= `DDIL_POL_RST;
      allow       <= `DDIL_ALLOW_RST;
      reset_btn_d <= 1'b0;
      enable_d    <= 1'b0;
    end else begin
      reset_btn_d <= reset_btn_s;
      enable_d    <= enable_s;
      if (reg_wr && (reg_addr == `DDIL_A_MODE)) begin
        fixed_off <= reg_wdata[`DDIL_MODE_BIT];
      end else if (reg_wr && (reg_addr == `DDIL_A_POL)) begin
        polarity <= reg_wdata[NIN-1:0];
      end else if (reg_wr && (reg_addr == `DDIL_A_ALLOW)) begin
        allow <= reg_wdata[3:0];
      end
    end
  end

  // reference-on: latched by run inputs in fixed mode, level-routed in
  // programmable mode; both give way to a missing run permit
  always @* begin
    next_ref_on = reference_on;
    if (!permit_s) begin
      next_ref_on = 1'b0;
    end else if (!fixed_off) begin
      if (cond[2] || cond[3]) begin
        next_ref_on = 1'b1;
      end
    end else begin
      next_ref_on = |ref_hit;
    end
  end

  // permit, stop and jog/run command outputs
  always @(posedge core_clk) begin
    if (!rst_n) begin
      start_allowed  <= 1'b0;
      speed_ref_zero <= 1'b1;
      stop_request   <= 1'b0;
      jog_rev_cmd    <= 1'b0;
      jog_fwd_cmd    <= 1'b0;
      run_rev_cmd    <= 1'b0;
      run_fwd_cmd    <= 1'b0;
      reference_on   <= 1'b0;
    end else begin
      start_allowed  <= permit_s;
      speed_ref_zero <= !permit_s;
      stop_request   <= !permit_s && !ramp_hold;
      reference_on   <= next_ref_on;
      if (!fixed_off) begin
        jog_rev_cmd <= permit_s && cond[0];
        jog_fwd_cmd <= permit_s && cond[1];
        run_rev_cmd <= permit_s && cond[2];
        run_fwd_cmd <= permit_s && cond[3];
      end else begin
        // fixed wiring kept; each allow bit also gates its own function
        jog_rev_cmd <= permit_s && cond[0] &&
                       allow[`DDIL_AL_JOG_REV];
        jog_fwd_cmd <= permit_s && cond[1] &&
                       allow[`DDIL_AL_JOG_FWD];
        run_rev_cmd <= permit_s && cond[2] &&
                       allow[`DDIL_AL_RUN_REV];
        run_fwd_cmd <= permit_s && cond[3] &&
                       allow[`DDIL_AL_RUN_FWD];
      end
    end
  end

  // enable handling: operate level, coast stop held until enable returns,
  // one-cycle ramp reset on the falling edge while running
  always @(posedge core_clk) begin
    if (!rst_n) begin
      drive_operate <= 1'b0;
      coast_stop    <= 1'b0;
      ramp_reset    <= 1'b0;
    end else begin
      drive_operate <= enable_s;
      ramp_reset    <= enable_d && !enable_s && drive_running;
      if (enable_s) begin
        coast_stop <= 1'b0;
      end else if (enable_d && drive_running) begin
        coast_stop <= 1'b1;
      end
    end
  end

  // gather target readback from the entries
  always @* begin
    rd_target = {DW{1'b0}};
    for (k = 0; k < NIN; k = k + 1) begin
      rd_target = rd_target | rd_vec[k*DW +: DW];
    end
  end

  // read decode; unmapped addresses and write-only apply read zero
  always @* begin
    next_rdata = {DW{1'b0}};
    if (reg_addr == `DDIL_A_STATUS) begin
      next_rdata[`DDIL_ST_PERMIT] = permit_s;
      next_rdata[`DDIL_ST_IN0 +: NIN] = in_s;
      next_rdata[`DDIL_ST_ENABLE] = enable_s;
    end else if (reg_addr == `DDIL_A_MODE) begin
      next_rdata[`DDIL_MODE_BIT] = fixed_off;
    end else if (reg_addr == `DDIL_A_POL) begin
      next_rdata[NIN-1:0] = polarity;
    end else if (reg_addr == `DDIL_A_ALLOW) begin
      next_rdata[3:0] = allow;
    end else if (reg_addr == `DDIL_A_DRIVE) begin
      next_rdata[`DDIL_DR_REFON]  = reference_on;
      next_rdata[`DDIL_DR_FIRING] = firing_on;
      next_rdata[`DDIL_DR_COAST]  = coast_stop;
    end else begin
      next_rdata = rd_target;
    end
  end

  // read data stands in the cycle after the strobe only
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end

endmodule // ddil_top

/* design/ddil_map.vh */
// constant map of the drive digital input block: register indices,
// field positions, reset values and timing figures.
// assumes inclusion by bare name from the top design file of the block.
`ifndef DDIL_MAP_VH
`define DDIL_MAP_VH

// register bus widths
`define DDIL_AW          8
`define DDIL_DW          16

// register addresses (word indices on the plain port)
`define DDIL_A_STATUS    8'h00
`define DDIL_A_TARGET0   8'h01
`define DDIL_A_MODE      8'h0a
`define DDIL_A_POL       8'h0b
`define DDIL_A_ALLOW     8'h0c
`define DDIL_A_APPLY     8'h0d
`define DDIL_A_DRIVE     8'h0e

// input count and destination field
`define DDIL_NIN         9
`define DDIL_DEST_W      11
`define DDIL_DEST_MAX    11'h7cf
`define DDIL_DEST_RST    11'h000
`define DDIL_REF_ON_DEST 11'h06f

// status register fields
`define DDIL_ST_PERMIT   0
`define DDIL_ST_IN0      1
`define DDIL_ST_ENABLE   10

// drive state register fields
`define DDIL_DR_REFON    0
`define DDIL_DR_FIRING   1
`define DDIL_DR_COAST    2

// allow register fields
`define DDIL_AL_JOG_REV  0
`define DDIL_AL_JOG_FWD  1
`define DDIL_AL_RUN_REV  2
`define DDIL_AL_RUN_FWD  3

// mode register field and reset values
`define DDIL_MODE_BIT    0
`define DDIL_POL_RST     9'h000
`define DDIL_ALLOW_RST   4'h0

// firing cutoff delay after enable loss
`define DDIL_OFF_DELAY_MS 30
`define DDIL_CLK_KHZ      125000

`endif

/* design/ddil_sync.v */
// two-stage synchroniser for a group of terminal inputs.
// assumes every bit is an unrelated level from outside the clock domain.
`timescale 1ns/10ps
module ddil_sync #(
  parameter W = 12
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // ddil_sync

/* design/ddil_delay.v */
// firing pulse cutoff timer: holds firing on for a fixed count after
// the enable level drops.
// assumes enable_ok is already synchronised to core_clk.
`timescale 1ns/10ps
module ddil_delay #(
  parameter CYCLES = 3750000,
  parameter CW     = 22
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire enable_ok,
  output reg  firing_on
);

  localparam [CW-1:0] LAST = CYCLES - 1;

  reg [CW-1:0] count;

  // count runs only while enable is absent; return of enable restarts it
  always @(posedge core_clk) begin
    if (!rst_n) begin
      count     <= {CW{1'b0}};
      firing_on <= 1'b0;
    end else if (enable_ok) begin
      count     <= {CW{1'b0}};
      firing_on <= 1'b1;
    end else if (firing_on) begin
      if (count == LAST) begin
        firing_on <= 1'b0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule // ddil_delay

/* tb/ddil_switches.sv */
// switch bank model: the terminals that a plc or hand switches drive
// assumes the bench sets want; contacts move one edge later, no bounce
`timescale 1ns/10ps
module ddil_switches (
  input  wire  core_clk,
  input  wire  [11:0] want,
  output logic [11:0] pins
);
  // levels move just after an edge, unrelated to what the block samples
  initial pins = 12'h000;
  always @(posedge core_clk) begin
    pins <= want;
  end
endmodule // ddil_switches

/* tb/ddil_top_sva.sv */
// checker of the terminal-to-command timing of the input block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module ddil_chk #(
  parameter OFF_DELAY_CYCLES = 3750000
) (
  input wire core_clk, rst_n, run_permit_input, drive_enable_input,
  input wire ramp_hold, drive_running, start_allowed, speed_ref_zero,
  input wire stop_request, jog_rev_cmd, jog_fwd_cmd, run_rev_cmd,
  input wire run_fwd_cmd, reference_on, drive_operate, firing_on,
  input wire coast_stop, ramp_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reg [2:0]  up;
  reg [31:0] lo;
  reg        armed;
  // age since reset, and cycles since operation dropped; the long delay
  // is counted here because a repetition cannot reach it
  always @(posedge core_clk) begin
    if (!rst_n) begin
      up <= 3'h0;
      lo <= 32'h0;
      armed <= 1'b0;
    end else begin
      if (up != 3'h7) up <= up + 3'h1;
      lo <= drive_operate ? 32'h0 : lo + 32'h1;
      if (drive_operate) armed <= firing_on;
    end
  end
  permit_follow_a: assert property (up == 3'h7 |->
    start_allowed == $past(run_permit_input, 3)) else $error("start level");
  ref_zero_a: assert property (speed_ref_zero == !start_allowed)
    else $error("speed reference not zeroed");
  stop_hold_a: assert property (up == 3'h7 |-> stop_request ==
    (!$past(run_permit_input, 3) && !$past(ramp_hold)))
    else $error("stop request wrong");
  operate_follow_a: assert property (up == 3'h7 |->
    drive_operate == $past(drive_enable_input, 3)) else $error("operate");
  fire_hold_a: assert property (armed && !drive_operate &&
    lo < OFF_DELAY_CYCLES - 2 |-> firing_on) else $error("firing cut early");
  fire_cut_a: assert property (!drive_operate &&
    lo > OFF_DELAY_CYCLES + 2 |-> !firing_on) else $error("firing cut late");
  coast_stop_a: assert property ($fell(drive_operate) &&
    $past(drive_running) |-> coast_stop && ramp_reset)
    else $error("no coast stop");
  ramp_pulse_a: assert property (ramp_reset |=> !ramp_reset)
    else $error("ramp reset too long");
  ref_gate_a: assert property (!start_allowed |-> !reference_on)
    else $error("reference on without permit");
  cmd_gate_a: assert property (!start_allowed |-> !(jog_rev_cmd ||
    jog_fwd_cmd || run_rev_cmd || run_fwd_cmd)) else $error("cmd w/o permit");
endmodule // ddil_chk

bind ddil_top ddil_chk #(.OFF_DELAY_CYCLES(OFF_DELAY_CYCLES)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .run_permit_input(run_permit_input),
  .drive_enable_input(drive_enable_input), .ramp_hold(ramp_hold),
  .drive_running(drive_running), .start_allowed(start_allowed),
  .speed_ref_zero(speed_ref_zero), .stop_request(stop_request),
  .jog_rev_cmd(jog_rev_cmd), .jog_fwd_cmd(jog_fwd_cmd),
  .run_rev_cmd(run_rev_cmd), .run_fwd_cmd(run_fwd_cmd),
  .reference_on(reference_on), .drive_operate(drive_operate),
  .firing_on(firing_on), .coast_stop(coast_stop), .ramp_reset(ramp_reset));

/* tb/tb.sv */
// self-checking bench of the drive input block with a switch bank model
// assumes the block cuts firing 20 cycles after enable loss here
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  typedef struct packed {
    logic m; logic [3:0] pol; logic [3:0] al; logic [4:0] pin;
    logic [3:0] cmd; logic ron;
  } ddil_row_t;
  // pin is {five,four,three,two,permit}; cmd is {jog rev,jog fwd,run rev,fwd}
  localparam ddil_row_t ROWS [0:8] = '{
    '{1'b0, 4'h0, 4'h0, 5'h03, 4'h8, 1'b0}, '{1'b0, 4'h0, 4'h0, 5'h05, 4'h4, 1'b0},
    '{1'b0, 4'h0, 4'h0, 5'h09, 4'h2, 1'b1}, '{1'b0, 4'h0, 4'h0, 5'h11, 4'h1, 1'b1},
    '{1'b0, 4'h0, 4'h0, 5'h1e, 4'h0, 1'b0}, '{1'b0, 4'h1, 4'h0, 5'h01, 4'h8, 1'b0},
    '{1'b1, 4'h0, 4'h0, 5'h1f, 4'h0, 1'b0}, '{1'b1, 4'h0, 4'hf, 5'h1f, 4'hf, 1'b0},
    '{1'b1, 4'h0, 4'h5, 5'h1f, 4'ha, 1'b0}};
  logic core_clk, rst_n, reg_wr, reg_rd, ramp_hold, drive_running;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, v;
  logic [11:0] want, pins;
  wire  [15:0] reg_rdata;
  wire  [98:0] route_dest;
  wire  [8:0]  route_level;
  wire  jr, jf, rr, rf, ron, stop, oper, fire, coast, srz;
  ddil_row_t r;
  int failures = 0, compares = 0, n;
  ddil_switches sw (.core_clk(core_clk), .want(want), .pins(pins));
  ddil_top #(.OFF_DELAY_CYCLES(20)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_permit_input(pins[0]),
    .logic_input_two(pins[1]), .logic_input_three(pins[2]),
    .logic_input_four(pins[3]), .logic_input_five(pins[4]),
    .logic_input_six(pins[5]), .logic_input_seven(pins[6]),
    .logic_input_eight(pins[7]), .logic_input_nine(pins[8]),
    .logic_input_ten(pins[9]), .drive_enable_input(pins[10]),
    .reset_button(pins[11]), .ramp_hold(ramp_hold),
    .drive_running(drive_running), .start_allowed(), .speed_ref_zero(srz),
    .stop_request(stop), .jog_rev_cmd(jr), .jog_fwd_cmd(jf),
    .run_rev_cmd(rr), .run_fwd_cmd(rf), .reference_on(ron),
    .drive_operate(oper), .firing_on(fire), .coast_stop(coast),
    .ramp_reset(), .route_dest(route_dest), .route_level(route_level));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // waits end one step after the edge so outputs have settled
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 16'h0000; want = 12'h400; ramp_hold = 1'b0; drive_running = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(1);
    for (int a = 1; a <= 12; a++) begin
      rd(a[7:0], v); `CHK("reset value", 16'h0000, v)
    end
    foreach (ROWS[i]) begin
      r = ROWS[i];
      want <= 12'h400; // permit off between rows clears the run latch
      wr(8'h0a, {15'h0, r.m}); wr(8'h0b, {12'h0, r.pol}); wr(8'h0c, {12'h0, r.al});
      want <= {2'b01, 5'h00, r.pin};
      cyc(6);
      `CHK("commands", r.cmd, {jr, jf, rr, rf})
      `CHK("reference on", r.ron, ron)
      rd(8'h00, v); `CHK("status", {5'h0, 1'b1, 5'h00, r.pin}, v)
    end
    // run input latches reference on; ramp hold blocks the stop
    wr(8'h0a, 16'h0000); want <= 12'h411; cyc(6); want <= 12'h401; cyc(6);
    `CHK("latched reference", 1'b1, ron)
    ramp_hold <= 1'b1; want <= 12'h400; cyc(6);
    `CHK("reference cleared", 1'b0, ron)
    `CHK("speed ref zero", 1'b1, srz)
    `CHK("stop held", 1'b0, stop)
    ramp_hold <= 1'b0; cyc(2); `CHK("stop", 1'b1, stop)
    // range limit, pending target and apply action
    wr(8'h05, 16'h006f); wr(8'h05, 16'h07d0); rd(8'h05, v);
    `CHK("target", 16'h006f, v)
    wr(8'h09, 16'h07cf); rd(8'h09, v); `CHK("target max", 16'h07cf, v)
    `CHK("route pending", 11'h000, route_dest[44 +: 11])
    wr(8'h0d, 16'h0001); cyc(2); `CHK("route", 11'h06f, route_dest[44 +: 11])
    wr(8'h01, 16'h006f); cyc(1); want <= 12'hc00; cyc(6); want <= 12'h400;
    `CHK("button apply", 11'h06f, route_dest[10:0])
    // programmable reference on through input six, polarity, permit gate
    wr(8'h0a, 16'h0001); want <= 12'h421; cyc(6);
    `CHK("prog reference", 1'b1, ron)
    `CHK("level", 1'b1, route_level[4])
    wr(8'h0b, 16'h0010); cyc(3); `CHK("inverted", 1'b0, route_level[4])
    wr(8'h0b, 16'h0000); want <= 12'h420; cyc(6);
    `CHK("no permit", 1'b0, ron)
    rd(8'h20, v); `CHK("unmapped", 16'h0000, v)
    wr(8'h00, 16'hffff); rd(8'h00, v); `CHK("ro status", 16'h0420, v)
    // enable loss while running
    drive_running <= 1'b1; want <= 12'h000; n = 0;
    while (fire !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      failures++;
      conclude();
    end
    `CHK("cutoff delay", 1'b1, (n >= 22 && n <= 26))
    `CHK("operate", 1'b0, oper)
    `CHK("coast", 1'b1, coast)
    rd(8'h0e, v); `CHK("drive state", 16'h0004, v)
    drive_running <= 1'b0; want <= 12'h400; cyc(6);
    `CHK("coast end", 1'b0, coast)
    // reset in mid-run restores the mapping bit default
    wr(8'h0a, 16'h0001); rst_n <= 1'b0; cyc(2); rst_n <= 1'b1; cyc(1);
    rd(8'h0a, v); `CHK("mode default", 16'h0000, v)
    conclude();
  end
endmodule // tb
